// ---- logic/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

  // Register offsets on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_INDEX = 4'h1;
  localparam logic [3:0] OFS_OBJ_HIGH = 4'h2;
  localparam logic [3:0] OFS_OBJ_LOW = 4'h3;
  localparam logic [3:0] OFS_SECURITY = 4'h4;
  localparam logic [3:0] OFS_MARGIN = 4'h5;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;

  // Status register layout
  localparam int ST_DONE_BIT = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int ST_PVIOL_BIT = 4;
  localparam int ST_VERR_HI_BIT = 1;
  localparam int ST_VERR_LO_BIT = 0;

  // Security register layout
  localparam int BACKDOOR_KEY_ENABLE_HI = 7;
  localparam int BACKDOOR_KEY_ENABLE_LO = 6;
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ENABLED = 2'h2;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // Command codes and object layout
  localparam logic [7:0] CMD_KEY_VERIFY = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
  localparam logic [7:0] CMD_FACTORY_MARGIN = 8'h0E;
  localparam int OBJ_DEPTH = 8;
  localparam logic [2:0] IDX_ADDR_LO = 3'h1;
  localparam logic [2:0] IDX_SETTING = 3'h2;
  localparam logic [2:0] IDX_KEY_LAST = 3'h4;
  localparam logic [2:0] IDX_MARGIN_LAST = 3'h2;
  localparam logic [15:0] KEY_BASE = 16'h0400;
  localparam int NUM_KEYS = 4;

  // Margin settings
  localparam int MARGIN_W = 3;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_USER_ERASED = 16'h0001;
  localparam logic [15:0] MARGIN_USER_PROG = 16'h0002;
  localparam logic [15:0] MARGIN_FACT_ERASED = 16'h0003;
  localparam logic [15:0] MARGIN_FACT_PROG = 16'h0004;

  // Interrupt status layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCESS_ERROR_FLAG = 1;
  localparam int IRQ_UNSECURED = 2;

  // Reset values
  localparam logic [2:0] INDEX_RST = 3'h0;
  localparam logic [15:0] OBJ_RST = 16'h0000;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [2:0] MARGIN_RST = 3'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_KEY_REQ, ST_KEY_CHK, ST_FINISH} seq_state_t;

endpackage : flash_cmd_pkg

// ---- logic/flash_key_margin_commands.sv ----
`timescale 1ns/1ns
module flash_key_margin_commands
#(
  parameter int NUM_BLOCKS = 1,
  parameter int BLOCK_SHIFT = 14,
  parameter logic [23:0] BLOCK_BASE = 24'h004000
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic [7:0] nv_security_byte,
  input wire logic special_mode,
  output logic key_rd_en,
  output logic [15:0] key_rd_addr,
  input wire logic [15:0] key_rd_data,
  output logic device_secure,
  output logic [NUM_BLOCKS*flash_cmd_pkg::MARGIN_W-1:0] margin_level
);
  import flash_cmd_pkg::*;

  localparam int BLK_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

  // Geometry the address decoder cannot serve
  if (NUM_BLOCKS < 1 || BLOCK_SHIFT < 1 || BLOCK_SHIFT > 22) begin : g_bad_geometry
    $error("flash_key_margin_commands: unsupported block geometry");
  end

  logic [7:0] sec_meta_r;
  logic [7:0] sec_sync_r;
  logic mode_meta_r;
  logic mode_sync_r;
  logic [7:0] security_r;
  logic secured_r;
  logic lockout_r;
  logic done_r;
  logic acc_err_r;
  logic launch_r;
  logic [2:0] idx_r;
  logic [15:0] obj_word_r [OBJ_DEPTH];
  logic [MARGIN_W-1:0] margin_r [NUM_BLOCKS];
  logic [BLK_W-1:0] last_blk_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [1:0] key_i_r;
  logic [1:0] key_i_nxt;
  logic match_r;
  logic match_nxt;
  logic launch_now;
  logic launch_err;
  logic go_key;
  logic go_margin;
  logic err_set;
  logic release_set;
  logic key_last;
  logic [7:0] cmd_code;
  logic [23:0] g_addr;
  logic [24:0] rel_addr;
  logic [24:0] span;
  logic addr_ok;
  logic [BLK_W-1:0] blk_sel;
  logic [15:0] setting;
  logic user_mode_ok;
  logic fact_mode_ok;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [2:0] key_obj_idx;

  // Pin inputs pass two flops; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    sec_meta_r <= nv_security_byte;
    sec_sync_r <= sec_meta_r;
    mode_meta_r <= special_mode;
    mode_sync_r <= mode_meta_r;
  end

  // Security byte is captured while reset is held, so hold reset long enough
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      security_r <= sec_sync_r;
      secured_r <= (sec_sync_r[1:0] != SEC_UNSECURED);
      lockout_r <= 1'b0;
    end
    else if (state_r == ST_KEY_CHK && key_last)
    begin
      if (match_nxt)
        secured_r <= 1'b0;
      else
        lockout_r <= 1'b1;
    end
  end

  // Launch is a write of one to the complete flag while idle and clean
  assign launch_now = reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_DONE_BIT] &&
                      done_r && !acc_err_r;

  // Complete flag and access error; the error set wins over its clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      done_r <= 1'b1;
      acc_err_r <= 1'b0;
      launch_r <= 1'b0;
    end
    else
    begin
      launch_r <= launch_now;
      if (state_r == ST_FINISH)
        done_r <= 1'b1;
      else if (launch_now)
        done_r <= 1'b0;
      if (err_set)
        acc_err_r <= 1'b1;
      else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_ACCESS_ERROR_FLAG_BIT])
        acc_err_r <= 1'b0;
    end
  end

  // Index and object words are frozen while a command runs
  always_ff @(posedge core_clk)
  begin
    if (rst)
      idx_r <= INDEX_RST;
    else if (done_r && reg_wr && reg_addr == OFS_INDEX)
      idx_r <= reg_wdata[2:0];
  end

  for (genvar i = 0; i < OBJ_DEPTH; i++) begin : g_obj
    // One command object word per index
    always_ff @(posedge core_clk)
    begin
      if (rst)
        obj_word_r[i] <= OBJ_RST;
      else if (done_r && reg_wr && idx_r == 3'(i))
      begin
        if (reg_addr == OFS_OBJ_HIGH)
          obj_word_r[i][15:8] <= reg_wdata;
        else if (reg_addr == OFS_OBJ_LOW)
          obj_word_r[i][7:0] <= reg_wdata;
      end
    end
  end

  // Parameter decode from the object words
  assign cmd_code = obj_word_r[0][15:8];
  assign g_addr = {obj_word_r[0][7:0], obj_word_r[IDX_ADDR_LO]};
  assign setting = obj_word_r[IDX_SETTING];
  assign rel_addr = {1'b0, g_addr} - {1'b0, BLOCK_BASE};
  assign span = 25'(NUM_BLOCKS) << BLOCK_SHIFT;
  assign addr_ok = (g_addr >= BLOCK_BASE) && (rel_addr < span);
  assign blk_sel = BLK_W'(rel_addr >> BLOCK_SHIFT);
  // Secured parts in normal mode lose margin reads; factory levels need special mode
  assign user_mode_ok = !secured_r || mode_sync_r;
  assign fact_mode_ok = mode_sync_r;

  // Launch checks, evaluated one cycle after the launch write
  always_comb
  begin
    launch_err = 1'b0;
    go_key = 1'b0;
    go_margin = 1'b0;
    unique case (cmd_code)
      CMD_KEY_VERIFY:
      begin
        if (idx_r != IDX_KEY_LAST ||
            security_r[BACKDOOR_KEY_ENABLE_HI:BACKDOOR_KEY_ENABLE_LO] != BACKDOOR_KEY_ENABLE_ENABLED ||
            lockout_r)
          launch_err = 1'b1;
        else
          go_key = 1'b1;
      end
      CMD_USER_MARGIN:
      begin
        if (idx_r != IDX_MARGIN_LAST || !user_mode_ok || !addr_ok ||
            setting > MARGIN_USER_PROG)
          launch_err = 1'b1;
        else
          go_margin = 1'b1;
      end
      CMD_FACTORY_MARGIN:
      begin
        if (idx_r != IDX_MARGIN_LAST || !fact_mode_ok || !addr_ok ||
            setting > MARGIN_FACT_PROG)
          launch_err = 1'b1;
        else
          go_margin = 1'b1;
      end
      default:
        launch_err = 1'b1;
    endcase
  end

  assign key_last = (key_i_r == 2'(NUM_KEYS - 1));
  assign key_obj_idx = 3'({1'b0, key_i_r}) + IDX_ADDR_LO;

  // Sequencer next state; keys are fetched one at a time from the flash array
  always_comb
  begin
    state_nxt = state_r;
    key_i_nxt = key_i_r;
    match_nxt = match_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (launch_r)
        begin
          if (go_key)
          begin
            state_nxt = ST_KEY_REQ;
            key_i_nxt = 2'h0;
            match_nxt = 1'b1;
          end
          else
            state_nxt = ST_FINISH;
        end
      end
      ST_KEY_REQ:
        state_nxt = ST_KEY_CHK;
      ST_KEY_CHK:
      begin
        // All keys are read even after a miss, so timing does not leak the match
        match_nxt = match_r && (key_rd_data == obj_word_r[key_obj_idx]);
        if (key_last)
          state_nxt = ST_FINISH;
        else
        begin
          state_nxt = ST_KEY_REQ;
          key_i_nxt = key_i_r + 2'h1;
        end
      end
      ST_FINISH:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer state and flash key read port
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      key_i_r <= 2'h0;
      match_r <= 1'b0;
      key_rd_en <= 1'b0;
      key_rd_addr <= KEY_BASE;
    end
    else
    begin
      state_r <= state_nxt;
      key_i_r <= key_i_nxt;
      match_r <= match_nxt;
      key_rd_en <= (state_nxt == ST_KEY_REQ);
      key_rd_addr <= KEY_BASE + 16'(key_i_nxt);
    end
  end

  assign err_set = (state_r == ST_IDLE && launch_r && launch_err) ||
                   (state_r == ST_KEY_CHK && key_last && !match_nxt);
  assign release_set = state_r == ST_KEY_CHK && key_last && match_nxt && secured_r;

  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_margin
    // Level stays until a later margin command names this block
    always_ff @(posedge core_clk)
    begin
      if (rst)
        margin_r[b] <= MARGIN_RST;
      else if (state_r == ST_IDLE && launch_r && go_margin && blk_sel == BLK_W'(b))
        margin_r[b] <= setting[MARGIN_W-1:0];
    end
    assign margin_level[b*MARGIN_W +: MARGIN_W] = margin_r[b];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      last_blk_r <= '0;
    else if (state_r == ST_IDLE && launch_r && go_margin)
      last_blk_r <= blk_sel;
  end

  // Interrupt status: read clears, a same-cycle event still lands
  assign irq_ev = {release_set, err_set, state_r == ST_FINISH};
  assign irq_stat_nxt = ((reg_rd && reg_addr == OFS_IRQ_STATUS) ? '0 : irq_stat_r) | irq_ev;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr && reg_addr == OFS_IRQ_MASK)
        irq_mask_r <= reg_wdata[IRQ_W-1:0];
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      unique case (reg_addr)
        OFS_STATUS:
          reg_rdata <= {done_r, 1'b0, acc_err_r, 5'h00};
        OFS_INDEX:
          reg_rdata <= {5'h00, idx_r};
        OFS_OBJ_HIGH:
          reg_rdata <= obj_word_r[idx_r][15:8];
        OFS_OBJ_LOW:
          reg_rdata <= obj_word_r[idx_r][7:0];
        OFS_SECURITY:
          reg_rdata <= security_r;
        OFS_MARGIN:
          reg_rdata <= {lockout_r, secured_r, 3'h0, margin_r[last_blk_r]};
        OFS_IRQ_STATUS:
          reg_rdata <= {5'h00, irq_stat_r};
        OFS_IRQ_MASK:
          reg_rdata <= {5'h00, irq_mask_r};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end

  assign device_secure = secured_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_launch_clears_done:
  assert property (launch_now |=> !done_r && launch_r)
    else $error("launch did not clear complete flag");

  a_key_enable_err:
  assert property (state_r == ST_IDLE && launch_r && cmd_code == CMD_KEY_VERIFY &&
                   security_r[BACKDOOR_KEY_ENABLE_HI:BACKDOOR_KEY_ENABLE_LO] != BACKDOOR_KEY_ENABLE_ENABLED
                   |=> acc_err_r && state_r == ST_FINISH)
    else $error("disabled key verify did not raise access error");

  a_key_index_err:
  assert property (state_r == ST_IDLE && launch_r && cmd_code == CMD_KEY_VERIFY &&
                   idx_r != IDX_KEY_LAST |=> acc_err_r ##1 done_r)
    else $error("bad key index not rejected");

  a_key_fetch_addr:
  assert property ($rose(state_r == ST_KEY_REQ) && $past(state_r) == ST_IDLE
                   |-> key_rd_en && key_rd_addr == KEY_BASE)
    else $error("first key fetch not at key base");

  a_key_duration:
  assert property (state_r == ST_IDLE && launch_r && go_key
                   |=> !done_r [*8] ##2 done_r)
    else $error("key verify completion timing wrong");

  a_release_match:
  assert property (state_r == ST_KEY_CHK && key_last && match_nxt |=> !device_secure)
    else $error("matching keys did not release security");

  a_lockout_holds:
  assert property (lockout_r && state_r == ST_IDLE && launch_r && cmd_code == CMD_KEY_VERIFY
                   |=> acc_err_r && $stable(device_secure) && state_r == ST_FINISH)
    else $error("locked key verify not aborted");

  a_margin_apply:
  assert property (state_r == ST_IDLE && launch_r && go_margin
                   |=> margin_r[$past(blk_sel)] == $past(setting[MARGIN_W-1:0]) ##1 done_r)
    else $error("margin level not applied before completion");

  a_margin_stable:
  assert property (!(state_r == ST_IDLE && launch_r && go_margin) |=> $stable(margin_level))
    else $error("margin level changed without a command");

  a_user_setting_err:
  assert property (state_r == ST_IDLE && launch_r && cmd_code == CMD_USER_MARGIN &&
                   setting > MARGIN_USER_PROG |=> acc_err_r && $stable(margin_level))
    else $error("bad user margin setting accepted");

  a_factory_mode_err:
  assert property (state_r == ST_IDLE && launch_r && cmd_code == CMD_FACTORY_MARGIN &&
                   !mode_sync_r |=> acc_err_r && $stable(margin_level))
    else $error("factory margin accepted outside special mode");

  a_error_completes:
  assert property (state_r == ST_IDLE && launch_r && launch_err
                   |=> $stable(device_secure) && $stable(margin_level) ##1 done_r)
    else $error("failed launch did not complete cleanly");

  c_key_release: cover property (state_r == ST_KEY_CHK && key_last && match_nxt);
  c_key_mismatch: cover property (state_r == ST_KEY_CHK && key_last && !match_nxt);
  c_factory_apply: cover property (state_r == ST_IDLE && launch_r && go_margin &&
                                   cmd_code == CMD_FACTORY_MARGIN);
  c_irq_raised: cover property ($rose(irq));

endmodule : flash_key_margin_commands

// ---- verif/flash_key_margin_commands_tb_top.sv ----
`timescale 1ns/1ns
module flash_key_margin_commands_tb_top;
  import flash_cmd_pkg::*;
  localparam logic [23:0] BLK_LO = 24'h004000;
  localparam logic [23:0] BLK_HI = 24'h008000;
  logic core_clk;
  logic rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq;
  logic [7:0] nv_security_byte;
  logic special_mode;
  logic key_rd_en;
  logic [15:0] key_rd_addr;
  logic [15:0] key_rd_data;
  logic device_secure;
  logic [MARGIN_W-1:0] margin_level;
  logic [15:0] key_tab [NUM_KEYS];
  logic [15:0] key_try [NUM_KEYS];
  logic [2:0] exp_lvl;
  logic exp_sec;
  int err_total;
  int samples_checked;

  flash_key_margin_commands #(.NUM_BLOCKS(1), .BLOCK_SHIFT(14), .BLOCK_BASE(BLK_LO)) dut_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .nv_security_byte(nv_security_byte), .special_mode(special_mode),
    .key_rd_en(key_rd_en), .key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data),
    .device_secure(device_secure), .margin_level(margin_level)
  );

  // Free running bus clock, 40 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // Flash array answers the cycle after a key read; between reads the data toggles
  // so a design that samples at the wrong cycle sees garbage
  always @(posedge core_clk)
  begin
    if (key_rd_en === 1'b1)
    begin
      key_rd_data <= key_tab[key_rd_addr[1:0]];
      chk(key_rd_addr & 16'hFFFC, KEY_BASE);
    end
    else
      key_rd_data <= ~key_rd_data;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic ld(input logic [2:0] i, input logic [15:0] w);
    wr(OFS_INDEX, {5'h00, i});
    wr(OFS_OBJ_HIGH, w[15:8]);
    wr(OFS_OBJ_LOW, w[7:0]);
  endtask : ld

  // Launch, wait for completion, check the error flag, clear it if set
  task automatic launch(input logic exp_err);
    logic [7:0] s;
    int n;
    wr(OFS_STATUS, 8'h80);
    s = 8'h00;
    for (n = 0; n < 40 && s[ST_DONE_BIT] !== 1'b1; n++)
      rd(OFS_STATUS, s);
    chk(s[ST_DONE_BIT], 1'b1);
    chk(s[ST_ACCESS_ERROR_FLAG_BIT], exp_err);
    if (s[ST_ACCESS_ERROR_FLAG_BIT] === 1'b1)
      wr(OFS_STATUS, 8'h20);
  endtask : launch

  function automatic logic m_err(input logic [7:0] c, input logic [23:0] a,
    input logic [15:0] s, input logic [2:0] ix);
    logic bad;
    bad = (ix != IDX_MARGIN_LAST) || (a < BLK_LO) || (a >= BLK_HI);
    if (c == CMD_USER_MARGIN)
      bad = bad || (s > MARGIN_USER_PROG) || (exp_sec && !special_mode);
    else
      bad = bad || (s > MARGIN_FACT_PROG) || !special_mode;
    return bad;
  endfunction : m_err

  // Margin command; model keeps the old level on any refusal
  task automatic margin_cmd(input logic [7:0] c, input logic [23:0] a,
    input logic [15:0] s, input logic [2:0] ix);
    logic e;
    logic [7:0] d;
    ld(3'h0, {c, a[23:16]});
    ld(IDX_ADDR_LO, a[15:0]);
    ld(IDX_SETTING, s);
    wr(OFS_INDEX, {5'h00, ix});
    // Mode pin was set by a non-blocking assignment, so judge only after some edges
    e = m_err(c, a, s, ix);
    launch(e);
    if (!e)
      exp_lvl = s[2:0];
    chk(margin_level, exp_lvl);
    rd(OFS_MARGIN, d);
    chk(d[2:0], exp_lvl);
  endtask : margin_cmd

  task automatic key_cmd(input logic [2:0] ix, input logic exp_err);
    int n;
    ld(3'h0, {CMD_KEY_VERIFY, 8'h00});
    for (n = 0; n < NUM_KEYS; n++)
      ld(3'(n + 1), key_try[n]);
    wr(OFS_INDEX, {5'h00, ix});
    launch(exp_err);
    chk(device_secure, exp_sec);
  endtask : key_cmd

  task automatic do_reset(input logic [7:0] nv);
    logic [7:0] d;
    @(posedge core_clk);
    rst <= 1'b1;
    nv_security_byte <= nv;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    exp_lvl = MARGIN_RST;
    exp_sec = (nv[1:0] != 2'b10);
    rd(OFS_STATUS, d);
    chk(d, 8'h80);
    rd(OFS_SECURITY, d);
    chk(d[BACKDOOR_KEY_ENABLE_HI:BACKDOOR_KEY_ENABLE_LO], nv[7:6]);
    chk(device_secure, exp_sec);
    chk(margin_level, MARGIN_RST);
  endtask : do_reset

  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // Hang guard, well past the 1500 or so cycles the tests need
  initial
  begin
    #(40 * 60000);
    err_total++;
    close_out;
  end

  initial
  begin
    logic [7:0] d;
    int n;
    logic [7:0] c;
    logic [23:0] a;
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nv_security_byte = 8'h80;
    special_mode = 1'b0;
    key_rd_data = 16'h0000;
    void'($urandom(70038));
    for (n = 0; n < NUM_KEYS; n++)
    begin
      key_tab[n] = $urandom();
      key_try[n] = key_tab[n];
    end
    do_reset(8'h80);
    // Unmapped read gives zero, index reads back
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk(d, 8'h00);
    wr(OFS_INDEX, 8'h03);
    rd(OFS_INDEX, d);
    chk(d[2:0], 3'h3);
    // Secured, user mode: user margin is unavailable
    margin_cmd(CMD_USER_MARGIN, BLK_LO, MARGIN_USER_ERASED, IDX_MARGIN_LAST);
    // Wrong final index, then correct keys release security
    key_cmd(3'h3, 1'b1);
    exp_sec = 1'b0;
    key_cmd(IDX_KEY_LAST, 1'b0);
    // Unsecured: every user setting, then edge cases
    for (n = 0; n < 4; n++)
      margin_cmd(CMD_USER_MARGIN, BLK_HI - 24'h1, n, IDX_MARGIN_LAST);
    margin_cmd(CMD_USER_MARGIN, BLK_LO, MARGIN_USER_PROG, 3'h1);
    margin_cmd(CMD_USER_MARGIN, BLK_HI, MARGIN_USER_ERASED, IDX_MARGIN_LAST);
    margin_cmd(CMD_FACTORY_MARGIN, BLK_LO, MARGIN_FACT_ERASED, IDX_MARGIN_LAST);
    special_mode <= 1'b1;
    for (n = 0; n < 6; n++)
      margin_cmd(CMD_FACTORY_MARGIN, BLK_LO + n, n, IDX_MARGIN_LAST);
    // Random mix of margin commands, modes, addresses and settings
    for (n = 0; n < 24; n++)
    begin
      special_mode <= $urandom_range(1, 0);
      c = ($urandom_range(1, 0) == 1) ? CMD_FACTORY_MARGIN : CMD_USER_MARGIN;
      a = BLK_LO - 24'h10 + $urandom_range(16'h4020, 0);
      margin_cmd(c, a, $urandom_range(6, 0), ($urandom_range(7, 0) == 0) ? 3'h1 : 3'h2);
    end
    // Interrupt: done bit masked in, then read-clear, then masked out
    rd(OFS_IRQ_STATUS, d);
    wr(OFS_IRQ_MASK, 8'h01);
    special_mode <= 1'b1;
    margin_cmd(CMD_FACTORY_MARGIN, BLK_LO, MARGIN_NORMAL, IDX_MARGIN_LAST);
    chk(irq, 1'b1);
    rd(OFS_IRQ_STATUS, d);
    chk(d[IRQ_DONE], 1'b1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h00);
    margin_cmd(CMD_FACTORY_MARGIN, BLK_LO, MARGIN_USER_PROG, IDX_MARGIN_LAST);
    chk(irq, 1'b0);
    // Reset drops margin; a bad key locks the command until reset
    do_reset(8'h80);
    key_try[2] = ~key_tab[2];
    key_cmd(IDX_KEY_LAST, 1'b1);
    key_try[2] = key_tab[2];
    key_cmd(IDX_KEY_LAST, 1'b1);
    do_reset(8'h80);
    exp_sec = 1'b0;
    key_cmd(IDX_KEY_LAST, 1'b0);
    // Release raises done and unsecured status bits only
    rd(OFS_IRQ_STATUS, d);
    chk(d, 8'h05);
    // Key access disabled by the enable field
    do_reset(8'h40);
    key_cmd(IDX_KEY_LAST, 1'b1);
    // Refused verify raises done and access error status bits, no release
    rd(OFS_IRQ_STATUS, d);
    chk(d, 8'h03);
    close_out;
  end
endmodule : flash_key_margin_commands_tb_top
